// *** rtl/gdcio_defs.svh ***
// Purpose: timing counts and reset values for the gauge discrete control block
// Assumes: 100 MHz mclk_i
// Notes:   definitions only
`ifndef GDCIO_DEFS_SVH
`define GDCIO_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define GDCIO_CLK_MHZ          100
`define GDCIO_DEB_US           5
`define GDCIO_DEB_CYC          (`GDCIO_DEB_US * `GDCIO_CLK_MHZ)
`define GDCIO_TICK_MS          100
`define GDCIO_TICK_CYC         (`GDCIO_TICK_MS * 1000 * `GDCIO_CLK_MHZ)
`define GDCIO_TICKS_PER_MIN    600
`define GDCIO_DEGAS_MIN_LO     2
`define GDCIO_DEGAS_MIN_HI     10

// ****************************************
// widths and reset values
// ****************************************
`define GDCIO_DEB_W            10
`define GDCIO_TICK_W           24
`define GDCIO_DUR_W            13
`define GDCIO_MIN_W            4
`define GDCIO_RST_INPUT        1'b1

`endif

// *** rtl/gdcio_pkg.sv ***
// Purpose: types for the gauge discrete control block
// Assumes: nothing
// Notes:   sources and degas states
package gdcio_pkg;

  // command pulses from serial and panel sources
  typedef struct packed {
    logic fil_on;
    logic fil_off;
    logic emis_hi;
    logic emis_lo;
    logic degas_on;
    logic degas_off;
  } gdcio_cmd_t;

  // filament and emission status carried to the outputs; degas_act is held at 0 and drives no output
  typedef struct packed {
    logic ion_gauge_filament;
    logic emis_4ma;
    logic degas_act;
  } gdcio_stat_t;

  typedef enum logic [1:0] {
    GDCIO_DG_IDLE,
    GDCIO_DG_RUN
  } gdcio_dg_t;

endpackage : gdcio_pkg

// *** rtl/gdcio_in_filt.sv ***
// Purpose: synchronise and debounce one ground-active input
// Assumes: asynchronous pin input
// Notes:   three flops, then a stable-time filter
`timescale 1ns/1ps
`include "gdcio_defs.svh"

module gdcio_in_filt
  import gdcio_pkg::*;
(
  input  wire logic mclk_i,    // system clock
  input  wire logic rst_n_i,   // sync reset, active low
  input  wire logic pin_n_i,   // raw pin, low = grounded
  output logic      grounded_o // filtered, high = grounded
);

  logic                    s1_r, s2_r, s3_r;
  logic                    s1_nxt, s2_nxt, s3_nxt;
  logic [`GDCIO_DEB_W-1:0] cnt_r, cnt_nxt;
  logic                    stab_r, stab_nxt;

  // next state: sync chain and stable counter
  always_comb begin
    s1_nxt   = pin_n_i;
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    cnt_nxt  = cnt_r;
    stab_nxt = stab_r;
    if (s2_r != s3_r) begin
      cnt_nxt = '0;
    end else if (s3_r == stab_r) begin
      cnt_nxt = '0;
    end else if (cnt_r == `GDCIO_DEB_W'(`GDCIO_DEB_CYC - 1)) begin
      stab_nxt = s3_r;
      cnt_nxt  = '0;
    end else begin
      cnt_nxt = cnt_r + `GDCIO_DEB_W'(1);
    end
  end

  // registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_r   <= `GDCIO_RST_INPUT;
      s2_r   <= `GDCIO_RST_INPUT;
      s3_r   <= `GDCIO_RST_INPUT;
      cnt_r  <= '0;
      stab_r <= `GDCIO_RST_INPUT;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      cnt_r  <= cnt_nxt;
      stab_r <= stab_nxt;
    end
  end

  assign grounded_o = ~stab_r;

endmodule : gdcio_in_filt

// *** rtl/gdcio_top.sv ***
// Purpose: discrete control and status logic of an ion vacuum gauge module
// Assumes: 100 MHz mclk_i, pins ground-active
// Notes:   serial and panel sources arrive as one-cycle command pulses
`timescale 1ns/1ps
`include "gdcio_defs.svh"

// Notes on behaviour
// - while the sensor input is held grounded the filament is on and the sensor active, unless a later fil_off command switches them off.
// - releasing ground on the sensor input, when it controls, switches the filament off.
// - a momentary ground pulse on the degas input starts a degas cycle.
// - degas runs for the set 2 to 10 minutes even after the trigger input is released.
// - a new degas start needs the trigger released and grounded again.
// - a grounded emission input selects 4 mA, otherwise 100 uA, unless an emis_hi or emis_lo command comes after the last pin change.
// - the degas status transistor is on exactly while degas runs.
// - the sensor status transistor is on exactly while the filament is on.
// - filament, emission and degas are also driven by serial and panel commands.
// - after reset the filament is off and the sensor inactive.
module gdcio_top
  import gdcio_pkg::*;
(
  input  wire logic                    mclk_i,        // system clock
  input  wire logic                    rst_n_i,       // sync reset, active low
  input  wire logic                    sens_n_i,      // sensor on/off pin, low = on
  input  wire logic                    degas_n_i,     // degas trigger pin, low = start
  input  wire logic                    emis_n_i,      // emission pin, low = 4 mA
  input  wire logic [`GDCIO_MIN_W-1:0] degas_min_i,   // degas minutes, 2..10
  input  wire gdcio_cmd_t              ser_cmd_i,     // serial command pulses
  input  wire gdcio_cmd_t              pnl_cmd_i,     // panel command pulses
  output logic                         fil_on_o,      // filament drive
  output logic                         emis_4ma_o,    // emission select, 1 = 4 mA
  output logic                         degas_on_o,    // degas drive
  output logic                         degas_stat_o,  // degas status pin, 1 = off
  output logic                         degas_stat_oe_n_o, // low = transistor on
  output logic                         sens_stat_o,   // sensor status pin, 1 = off
  output logic                         sens_stat_oe_n_o   // low = transistor on
);

  // ****************************************
  // input filters
  // ****************************************
  logic [2:0] pin_n;
  logic [2:0] gnd;
  assign pin_n = {emis_n_i, degas_n_i, sens_n_i};

  // one filter per ground-active pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      gdcio_in_filt u_filt (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .pin_n_i    (pin_n[gi]),
        .grounded_o (gnd[gi])
      );
    end
  endgenerate

  // ****************************************
  // edge detect on filtered levels
  // ****************************************
  logic [2:0] gnd_d_r, gnd_d_nxt;
  logic [2:0] fall, rise;

  // a change of a filtered level is one event
  always_comb begin
    gnd_d_nxt = gnd;
    fall      = gnd & ~gnd_d_r;       // became grounded
    rise      = ~gnd & gnd_d_r;       // ground released
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gnd_d_r <= 3'h0;
    end else begin
      gnd_d_r <= gnd_d_nxt;
    end
  end

  // any source command, one cycle wide
  function automatic logic any_cmd(input logic a, input logic b);
    any_cmd = a | b;
  endfunction : any_cmd

  // ****************************************
  // filament and emission
  // ****************************************
  gdcio_stat_t st_r, st_nxt;
  logic        deg_done;

  // pin edges and commands steer the filament; last event wins
  always_comb begin
    st_nxt = st_r;
    if (fall[0]) begin
      st_nxt.ion_gauge_filament = 1'b1;
    end else if (rise[0]) begin
      st_nxt.ion_gauge_filament = 1'b0;
    end else if (any_cmd(ser_cmd_i.fil_off, pnl_cmd_i.fil_off)) begin
      st_nxt.ion_gauge_filament = 1'b0;
    end else if (any_cmd(ser_cmd_i.fil_on, pnl_cmd_i.fil_on)) begin
      st_nxt.ion_gauge_filament = 1'b1;
    end
    if (fall[2]) begin
      st_nxt.emis_4ma = 1'b1;
    end else if (rise[2]) begin
      st_nxt.emis_4ma = 1'b0;
    end else if (any_cmd(ser_cmd_i.emis_hi, pnl_cmd_i.emis_hi)) begin
      st_nxt.emis_4ma = 1'b1;
    end else if (any_cmd(ser_cmd_i.emis_lo, pnl_cmd_i.emis_lo)) begin
      st_nxt.emis_4ma = 1'b0;
    end
    st_nxt.degas_act = 1'b0;
  end

  // ****************************************
  // degas timer
  // ****************************************
  gdcio_dg_t               dg_r, dg_nxt;
  logic [`GDCIO_TICK_W-1:0] tick_r, tick_nxt;
  logic [`GDCIO_DUR_W-1:0]  rem_r, rem_nxt;
  logic [`GDCIO_MIN_W-1:0]  mins;
  logic                     start, stop;

  // clamp the set minutes to the legal span
  always_comb begin
    if (degas_min_i < `GDCIO_MIN_W'(`GDCIO_DEGAS_MIN_LO)) begin
      mins = `GDCIO_MIN_W'(`GDCIO_DEGAS_MIN_LO);
    end else if (degas_min_i > `GDCIO_MIN_W'(`GDCIO_DEGAS_MIN_HI)) begin
      mins = `GDCIO_MIN_W'(`GDCIO_DEGAS_MIN_HI);
    end else begin
      mins = degas_min_i;
    end
  end

  // start on a fresh grounding or a degas_on command, so a held pin never retriggers
  assign start = fall[1] | any_cmd(ser_cmd_i.degas_on, pnl_cmd_i.degas_on);
  assign stop  = any_cmd(ser_cmd_i.degas_off, pnl_cmd_i.degas_off);
  assign deg_done = (rem_r == '0);

  // degas state machine
  always_comb begin
    dg_nxt   = dg_r;
    tick_nxt = tick_r;
    rem_nxt  = rem_r;
    case (dg_r)
      // a pin edge beats a same-cycle stop, a stop beats a command start
      GDCIO_DG_IDLE: begin
        if (fall[1] || (start && !stop)) begin
          dg_nxt   = GDCIO_DG_RUN;
          tick_nxt = '0;
          rem_nxt  = `GDCIO_DUR_W'(mins * `GDCIO_TICKS_PER_MIN);
        end
      end
      GDCIO_DG_RUN: begin
        if (fall[1] || (start && !stop)) begin
          tick_nxt = '0;
          rem_nxt  = `GDCIO_DUR_W'(mins * `GDCIO_TICKS_PER_MIN);
        end else if (stop) begin
          dg_nxt  = GDCIO_DG_IDLE;
          rem_nxt = '0;
        end else if (deg_done) begin
          dg_nxt = GDCIO_DG_IDLE;
        end else if (tick_r == `GDCIO_TICK_W'(`GDCIO_TICK_CYC - 1)) begin
          tick_nxt = '0;
          if (rem_r == `GDCIO_DUR_W'(1)) begin
            dg_nxt  = GDCIO_DG_IDLE;
            rem_nxt = '0;
          end else begin
            rem_nxt = rem_r - `GDCIO_DUR_W'(1);
          end
        end else begin
          tick_nxt = tick_r + `GDCIO_TICK_W'(1);
        end
      end
      default: begin
        dg_nxt = GDCIO_DG_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers and outputs
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r              <= '0;
      dg_r              <= GDCIO_DG_IDLE;
      tick_r            <= '0;
      rem_r             <= '0;
      fil_on_o          <= 1'b0;
      emis_4ma_o        <= 1'b0;
      degas_on_o        <= 1'b0;
      degas_stat_o      <= 1'b1;
      degas_stat_oe_n_o <= 1'b1;
      sens_stat_o       <= 1'b1;
      sens_stat_oe_n_o  <= 1'b1;
    end else begin
      st_r              <= st_nxt;
      dg_r              <= dg_nxt;
      tick_r            <= tick_nxt;
      rem_r             <= rem_nxt;
      fil_on_o          <= st_nxt.ion_gauge_filament;
      emis_4ma_o        <= st_nxt.emis_4ma;
      degas_on_o        <= (dg_nxt == GDCIO_DG_RUN);
      // open collector: drive low when on, release otherwise
      degas_stat_o      <= 1'b0;
      degas_stat_oe_n_o <= ~(dg_nxt == GDCIO_DG_RUN);
      sens_stat_o       <= 1'b0;
      sens_stat_oe_n_o  <= ~st_nxt.ion_gauge_filament;
    end
  end

endmodule : gdcio_top

// *** verif/gdcio_top_sva.sv ***
// Purpose: port assertions for gdcio_top
// Assumes: a pin change acts about 505 cycles later
// Notes:   bound to every gdcio_top below
`timescale 1ns/1ps
module gdcio_top_chk
  import gdcio_pkg::*;
(
  input  wire logic       mclk_i,            // clock
  input  wire logic       rst_n_i,           // reset
  input  wire logic       sens_n_i,          // sensor pin
  input  wire logic       degas_n_i,         // degas pin
  input  wire gdcio_cmd_t ser_cmd_i,         // serial cmds
  input  wire gdcio_cmd_t pnl_cmd_i,         // panel cmds
  input  wire logic       fil_on_o,          // filament
  input  wire logic       emis_4ma_o,        // emission
  input  wire logic       degas_on_o,        // degas
  input  wire logic       degas_stat_oe_n_o, // degas status
  input  wire logic       sens_stat_oe_n_o   // sensor status
);
  logic [9:0] s_cnt_r, s_cnt_nxt, d_cnt_r, d_cnt_nxt;
  logic       s_d_r, d_d_r;
  gdcio_cmd_t cmd;
  // cycles since each pin changed, held at 600
  always_comb begin
    cmd       = ser_cmd_i | pnl_cmd_i;
    s_cnt_nxt = (sens_n_i != s_d_r) ? 10'h000 : s_cnt_r + {9'h000, s_cnt_r != 10'h258};
    d_cnt_nxt = (degas_n_i != d_d_r) ? 10'h000 : d_cnt_r + {9'h000, d_cnt_r != 10'h258};
  end
  // register the counters
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_cnt_r <= 10'h258;
      d_cnt_r <= 10'h258;
      s_d_r   <= 1'b1;
      d_d_r   <= 1'b1;
    end else begin
      s_cnt_r <= s_cnt_nxt;
      d_cnt_r <= d_cnt_nxt;
      s_d_r   <= sens_n_i;
      d_d_r   <= degas_n_i;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_sens_held; s_cnt_r == 10'h1fe && !sens_n_i; endsequence
  sequence s_sens_free; s_cnt_r == 10'h1fe && sens_n_i; endsequence
  sequence s_dg_held; d_cnt_r == 10'h1fe && !degas_n_i; endsequence
  a_sens_stat_tie: assert property (sens_stat_oe_n_o == !fil_on_o)
    else $error("sensor status wrong");
  a_dg_stat_tie: assert property (degas_stat_oe_n_o == !degas_on_o)
    else $error("degas status wrong");
  a_sens_pin_on: assert property (s_sens_held |-> fil_on_o)
    else $error("filament not on");
  a_sens_pin_off: assert property (s_sens_free |-> !fil_on_o)
    else $error("filament not off");
  a_degas_pin_run: assert property (s_dg_held |-> degas_on_o [*8])
    else $error("degas not running");
  a_fil_cmd_on: assert property (cmd.fil_on && !cmd.fil_off |=> fil_on_o)
    else $error("filament command lost");
  a_fil_cmd_off: assert property (cmd.fil_off |=> !fil_on_o)
    else $error("filament off lost");
  a_emis_cmd_hi: assert property (cmd.emis_hi |=> emis_4ma_o)
    else $error("emission high lost");
  a_emis_cmd_lo: assert property (cmd.emis_lo && !cmd.emis_hi |=> !emis_4ma_o)
    else $error("emission low lost");
  a_dg_cmd_on: assert property (cmd.degas_on && !cmd.degas_off |=> degas_on_o)
    else $error("degas start lost");
  a_dg_cmd_off: assert property (cmd.degas_off |=> !degas_on_o)
    else $error("degas stop lost");
  a_reset_off: assert property (disable iff (1'b0) !rst_n_i |=> !fil_on_o && !degas_on_o)
    else $error("reset left outputs on");
endmodule : gdcio_top_chk

bind gdcio_top gdcio_top_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sens_n_i(sens_n_i),
  .degas_n_i(degas_n_i), .ser_cmd_i(ser_cmd_i), .pnl_cmd_i(pnl_cmd_i), .fil_on_o(fil_on_o),
  .emis_4ma_o(emis_4ma_o), .degas_on_o(degas_on_o), .degas_stat_oe_n_o(degas_stat_oe_n_o),
  .sens_stat_oe_n_o(sens_stat_oe_n_o));

// *** verif/gdcio_ext.sv ***
// Purpose: external switch contacts and pulled-up status lines
// Assumes: contacts close to ground
// Notes:   a momentary degas press lasts 600 cycles
`timescale 1ns/1ps
module gdcio_ext (
  input  wire logic mclk_i,     // clock
  input  wire logic dg_hold_i,  // hold degas contact
  input  wire logic dg_push_i,  // start a momentary press
  input  wire logic dg_stat_i,  // degas status pin
  input  wire logic dg_oe_n_i,  // degas status enable
  input  wire logic s_stat_i,   // sensor status pin
  input  wire logic s_oe_n_i,   // sensor status enable
  output logic      degas_n_o,  // degas contact
  output logic      dg_lvl_o,   // degas status line
  output logic      s_lvl_o     // sensor status line
);
  logic [9:0] press_r = 10'h000;
  // press briefly, then let go
  always_ff @(posedge mclk_i) begin
    if (dg_push_i) press_r <= 10'h258;
    else if (press_r != 10'h000) press_r <= press_r - 10'h001;
  end
  assign degas_n_o = !(dg_hold_i || press_r != 10'h000);
  // open collector lines float to the pull-up
  assign dg_lvl_o  = dg_oe_n_i ? 1'b1 : dg_stat_i;
  assign s_lvl_o   = s_oe_n_i ? 1'b1 : s_stat_i;
endmodule : gdcio_ext

// *** verif/gdcio_top_test.sv ***
// Purpose: self-checking bench for gdcio_top
// Assumes: 100 MHz clock, inputs driven at the falling edge
// Notes:   the end of a degas run lies far beyond the 20000-cycle hang guard
`timescale 1ns/1ps
module gdcio_top_test
  import gdcio_pkg::*;
;
  logic       mclk_i = 1'b0, rst_n_i = 1'b0;
  logic       sens_gnd = 1'b0, emis_gnd = 1'b0, dg_hold = 1'b0, dg_push = 1'b0;
  gdcio_cmd_t ser = '0, pnl = '0;
  logic       degas_n, fil, emis, dg, dg_st, dg_oe_n, s_st, s_oe_n, dg_lvl, s_lvl;
  int         error_cnt = 0, cmp_count = 0, cyc = 0;
  wire  logic [6:0] outs = {fil, emis, dg, dg_oe_n, s_oe_n, dg_lvl, s_lvl};
  // rows: serial cmd, panel cmd, filament/emission/degas
  localparam logic [14:0] ROWS [8] = '{{6'h20, 6'h00, 3'b100}, {6'h00, 6'h08, 3'b110},
    {6'h0c, 6'h00, 3'b110}, {6'h00, 6'h04, 3'b100}, {6'h02, 6'h00, 3'b101},
    {6'h00, 6'h01, 3'b100}, {6'h20, 6'h10, 3'b000}, {6'h00, 6'h03, 3'b000}};
  always #5 mclk_i = ~mclk_i;
  gdcio_ext ext (.mclk_i(mclk_i), .dg_hold_i(dg_hold), .dg_push_i(dg_push), .dg_stat_i(dg_st),
    .dg_oe_n_i(dg_oe_n), .s_stat_i(s_st), .s_oe_n_i(s_oe_n), .degas_n_o(degas_n),
    .dg_lvl_o(dg_lvl), .s_lvl_o(s_lvl));
  gdcio_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sens_n_i(!sens_gnd), .degas_n_i(degas_n),
    .emis_n_i(!emis_gnd), .degas_min_i(4'h2), .ser_cmd_i(ser), .pnl_cmd_i(pnl),
    .fil_on_o(fil), .emis_4ma_o(emis), .degas_on_o(dg), .degas_stat_o(dg_st),
    .degas_stat_oe_n_o(dg_oe_n), .sens_stat_o(s_st), .sens_stat_oe_n_o(s_oe_n));
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // expected outputs from filament/emission/degas
  function automatic logic [6:0] ev(input logic [2:0] fed);
    return {fed, ~fed[0], ~fed[2], ~fed[0], ~fed[2]};
  endfunction : ev
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    tick(10);
    rst_n_i = 1'b1;
    tick(1);
    chk(outs, ev(3'b000));
    $display("test reset ended");
    foreach (ROWS[i]) begin
      ser = ROWS[i][14:9];
      pnl = ROWS[i][8:3];
      tick(1);
      ser = '0;
      pnl = '0;
      chk(outs, ev(ROWS[i][2:0]));
    end
    $display("test commands ended");
    sens_gnd = 1'b1;
    tick(100);
    sens_gnd = 1'b0;
    tick(600);
    chk(outs, ev(3'b000));
    sens_gnd = 1'b1;
    tick(600);
    chk(outs, ev(3'b100));
    sens_gnd = 1'b0;
    tick(600);
    chk(outs, ev(3'b000));
    emis_gnd = 1'b1;
    tick(600);
    chk(outs, ev(3'b010));
    emis_gnd = 1'b0;
    tick(600);
    chk(outs, ev(3'b000));
    $display("test pins ended");
    dg_push = 1'b1;
    tick(1);
    dg_push = 1'b0;
    tick(1300);
    chk(outs, ev(3'b001));
    pnl = 6'h01;
    tick(1);
    pnl = '0;
    chk(outs, ev(3'b000));
    dg_hold = 1'b1;
    tick(600);
    chk(outs, ev(3'b001));
    ser = 6'h01;
    tick(1);
    ser = '0;
    tick(600);
    chk(outs, ev(3'b000));
    dg_hold = 1'b0;
    tick(600);
    dg_hold = 1'b1;
    tick(600);
    chk(outs, ev(3'b001));
    $display("test degas ended");
    dg_hold = 1'b0;
    rst_n_i = 1'b0;
    tick(4);
    chk(outs, ev(3'b000));
    rst_n_i = 1'b1;
    tick(600);
    chk(outs, ev(3'b000));
    $display("test rerun ended");
    summarize();
  end
endmodule : gdcio_top_test
